/* verilog/ssc_status_pkg.sv */
/*
  Constants for the serial status, compare and interrupt-mask register bank:
  register offsets, status bit positions, reset values and AHB-Lite codes.
  Assumes it is compiled before any file that imports it.
*/
`default_nettype none

package ssc_status_pkg;

  // Bus, compare and interrupt source widths
  localparam int unsigned DATA_W    = 32;
  localparam int unsigned ADDR_W    = 32;
  localparam int unsigned CMP_W     = 16;
  localparam int unsigned SRC_W     = 12;

  // Register byte offsets
  localparam logic [7:0] OFF_COMPARE_A   = 8'h00;
  localparam logic [7:0] OFF_COMPARE_B   = 8'h04;
  localparam logic [7:0] OFF_STATUS      = 8'h08;
  localparam logic [7:0] OFF_IRQ_ENABLE  = 8'h0C;
  localparam logic [7:0] OFF_IRQ_DISABLE = 8'h10;
  localparam logic [7:0] OFF_MASK_VIEW   = 8'h14;
  localparam logic [7:0] OFF_SYNC_CTRL   = 8'h18;

  // Status and sync control bit positions
  localparam int unsigned BIT_TX_HOLDING_FREE     = 0;
  localparam int unsigned BIT_TX_FULLY_DRAINED    = 1;
  localparam int unsigned BIT_TX_COUNT_DONE       = 2;
  localparam int unsigned BIT_TX_COUNTS_BOTH_ZERO = 3;
  localparam int unsigned BIT_RX_WORD_AVAILABLE   = 4;
  localparam int unsigned BIT_RX_OVERWRITE_FLAG   = 5;
  localparam int unsigned BIT_RX_COUNT_DONE       = 6;
  localparam int unsigned BIT_RX_COUNTS_BOTH_ZERO = 7;
  localparam int unsigned BIT_COMPARE_A_HIT       = 8;
  localparam int unsigned BIT_COMPARE_B_HIT       = 9;
  localparam int unsigned BIT_TX_FRAME_SYNC_SEEN  = 10;
  localparam int unsigned BIT_RX_FRAME_SYNC_SEEN  = 11;
  localparam int unsigned BIT_TRANSMITTER_ON      = 16;
  localparam int unsigned BIT_RECEIVER_ON         = 17;
  localparam int unsigned BIT_SYNC_EDGE_SELECT    = 0;

  // Flags that hold until cleared, as opposed to live levels
  localparam logic [SRC_W-1:0] STICKY_BITS = 12'hF64;

  // Reset values
  localparam logic [SRC_W-1:0] MASK_RESET    = 12'h000;
  localparam logic [SRC_W-1:0] STICKY_RESET  = 12'h000;
  localparam logic [CMP_W-1:0] COMPARE_RESET = 16'h0000;
  localparam logic [DATA_W-1:0] RDATA_RESET  = 32'h0000_0000;

  // AHB-Lite codes
  localparam logic [1:0] HTRANS_IDLE   = 2'h0;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic       HRESP_OKAY    = 1'b0;

  // Frame-sync edge used for the transmit sync event
  typedef enum logic {
    EDGE_RISING  = 1'b0,
    EDGE_FALLING = 1'b1
  } sync_edge_t;

  localparam sync_edge_t SYNC_EDGE_RESET = EDGE_RISING;

endpackage

`default_nettype wire

/* verilog/serial_status_regs.sv */
/*
  Status, receive-compare and interrupt-mask register bank of a synchronous
  serial controller, reached as an AHB-Lite slave with zero wait states.
  Assumes the shifters, DMA counters and receiver live elsewhere on clk and
  feed this block with levels and one-cycle pulses; only the transmit frame
  sync line comes from a pin and is synchronised here.
*/
// The AHB-Lite slave port and the register offsets are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none

module serial_status_regs (
  input  wire logic                                   clk,
  input  wire logic                                   rst_n,
  // AHB-Lite slave
  input  wire logic                                   hsel,
  input  wire logic [ssc_status_pkg::ADDR_W-1:0]      haddr,
  input  wire logic [1:0]                             htrans,
  input  wire logic                                   hwrite,
  input  wire logic [2:0]                             hsize,
  input  wire logic [ssc_status_pkg::DATA_W-1:0]      hwdata,
  input  wire logic                                   hready,
  output logic                                        hreadyout,
  output logic                                        hresp,
  output logic [ssc_status_pkg::DATA_W-1:0]           hrdata,
  // Transmit side of the unit
  input  wire logic                                   tx_holding_free,
  input  wire logic                                   tx_fully_drained,
  input  wire logic                                   tx_count_reached_zero,
  input  wire logic                                   tx_count_written,
  input  wire logic                                   tx_count_is_zero,
  input  wire logic                                   tx_next_count_is_zero,
  input  wire logic                                   tx_frame_sync_pin,
  input  wire logic                                   transmitter_on,
  // Receive side of the unit
  input  wire logic                                   rx_word_available,
  input  wire logic                                   rx_word_load,
  input  wire logic                                   rx_count_reached_zero,
  input  wire logic                                   rx_count_written,
  input  wire logic                                   rx_count_is_zero,
  input  wire logic                                   rx_next_count_is_zero,
  input  wire logic                                   rx_sync_word_valid,
  input  wire logic [ssc_status_pkg::CMP_W-1:0]       rx_sync_word,
  input  wire logic                                   rx_frame_sync_event,
  input  wire logic                                   receiver_on,
  // Interrupt
  output logic                                        irq
);
  import ssc_status_pkg::*;

  logic                accept;
  logic [7:0]          acc_addr;
  logic                status_read;
  logic                wr_pend_q;
  logic [7:0]          wr_addr_q;
  logic                wr_compare_a;
  logic                wr_compare_b;
  logic                wr_enable;
  logic                wr_disable;
  logic                wr_sync_ctrl;
  logic [DATA_W-1:0]   hrdata_q;
  logic [DATA_W-1:0]   read_word;
  logic [CMP_W-1:0]    compare_a_q;
  logic [CMP_W-1:0]    compare_b_q;
  sync_edge_t          sync_edge_q;
  logic [SRC_W-1:0]    mask_q;
  logic [SRC_W-1:0]    sticky_q;
  logic [SRC_W-1:0]    sticky_d;
  logic [SRC_W-1:0]    set_vec;
  logic [SRC_W-1:0]    clr_vec;
  logic [SRC_W-1:0]    flags;
  logic                fs_meta_q;
  logic                fs_sync_q;
  logic                fs_prev_q;
  logic                fs_rise;
  logic                fs_fall;
  logic                tx_sync_event;
  logic                hit_a;
  logic                hit_b;

  // Address phase decode
  assign accept      = hsel && htrans[1] && hready;
  assign acc_addr    = haddr[7:0];
  assign status_read = accept && !hwrite && (acc_addr == OFF_STATUS);

  // Zero wait states, always OKAY
  assign hreadyout = 1'b1;
  assign hresp     = HRESP_OKAY;
  assign hrdata    = hrdata_q;

  // Write address held into the data phase
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
    end else begin
      wr_pend_q <= accept && hwrite;
      wr_addr_q <= acc_addr;
    end
  end

  assign wr_compare_a = wr_pend_q && (wr_addr_q == OFF_COMPARE_A);
  assign wr_compare_b = wr_pend_q && (wr_addr_q == OFF_COMPARE_B);
  assign wr_enable    = wr_pend_q && (wr_addr_q == OFF_IRQ_ENABLE);
  assign wr_disable   = wr_pend_q && (wr_addr_q == OFF_IRQ_DISABLE);
  assign wr_sync_ctrl = wr_pend_q && (wr_addr_q == OFF_SYNC_CTRL);

  // Compare values
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      compare_a_q <= COMPARE_RESET;
      compare_b_q <= COMPARE_RESET;
    end else begin
      if (wr_compare_a) begin
        compare_a_q <= hwdata[CMP_W-1:0];
      end
      if (wr_compare_b) begin
        compare_b_q <= hwdata[CMP_W-1:0];
      end
    end
  end

  // Edge select setting
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sync_edge_q <= SYNC_EDGE_RESET;
    end else if (wr_sync_ctrl) begin
      sync_edge_q <= sync_edge_t'(hwdata[BIT_SYNC_EDGE_SELECT]);
    end
  end

  // Frame-sync pin synchroniser and edge history
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      fs_meta_q <= 1'b0;
      fs_sync_q <= 1'b0;
      fs_prev_q <= 1'b0;
    end else begin
      fs_meta_q <= tx_frame_sync_pin;
      fs_sync_q <= fs_meta_q;
      fs_prev_q <= fs_sync_q;
    end
  end

  assign fs_rise = fs_sync_q && !fs_prev_q;
  assign fs_fall = !fs_sync_q && fs_prev_q;
  assign tx_sync_event = (sync_edge_q == EDGE_FALLING) ? fs_fall : fs_rise;

  assign hit_a = rx_sync_word_valid && (rx_sync_word == compare_a_q);
  assign hit_b = rx_sync_word_valid && (rx_sync_word == compare_b_q);

  // Sticky flag set and clear terms
  always_comb begin
    set_vec = '0;
    clr_vec = '0;
    set_vec[BIT_TX_COUNT_DONE]      = tx_count_reached_zero;
    clr_vec[BIT_TX_COUNT_DONE]      = tx_count_written;
    set_vec[BIT_RX_OVERWRITE_FLAG]  = rx_word_load && rx_word_available;
    clr_vec[BIT_RX_OVERWRITE_FLAG]  = status_read;
    set_vec[BIT_RX_COUNT_DONE]      = rx_count_reached_zero;
    clr_vec[BIT_RX_COUNT_DONE]      = rx_count_written;
    set_vec[BIT_COMPARE_A_HIT]      = hit_a;
    clr_vec[BIT_COMPARE_A_HIT]      = status_read;
    set_vec[BIT_COMPARE_B_HIT]      = hit_b;
    clr_vec[BIT_COMPARE_B_HIT]      = status_read;
    set_vec[BIT_TX_FRAME_SYNC_SEEN] = tx_sync_event;
    clr_vec[BIT_TX_FRAME_SYNC_SEEN] = status_read;
    set_vec[BIT_RX_FRAME_SYNC_SEEN] = rx_frame_sync_event;
    clr_vec[BIT_RX_FRAME_SYNC_SEEN] = status_read;
  end

  // Set wins over a clear in the same cycle
  assign sticky_d = ((sticky_q & ~clr_vec) | set_vec) & STICKY_BITS;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sticky_q <= STICKY_RESET;
    end else begin
      sticky_q <= sticky_d;
    end
  end

  // Sticky flags merged with the live levels: view of all interrupt sources
  always_comb begin
    flags = sticky_q;
    flags[BIT_TX_HOLDING_FREE]     = tx_holding_free;
    flags[BIT_TX_FULLY_DRAINED]    = tx_fully_drained;
    flags[BIT_TX_COUNTS_BOTH_ZERO] = tx_count_is_zero && tx_next_count_is_zero;
    flags[BIT_RX_WORD_AVAILABLE]   = rx_word_available;
    flags[BIT_RX_COUNTS_BOTH_ZERO] = rx_count_is_zero && rx_next_count_is_zero;
  end

  // Interrupt mask, one set/clear cell per source
  for (genvar i = 0; i < SRC_W; i++) begin : g_mask
    always_ff @(posedge clk) begin
      if (!rst_n) begin
        mask_q[i] <= MASK_RESET[i];
      end else if (wr_enable && hwdata[i]) begin
        mask_q[i] <= 1'b1;
      end else if (wr_disable && hwdata[i]) begin
        mask_q[i] <= 1'b0;
      end
    end
  end

  assign irq = |(flags & mask_q);

  // Read multiplexer, unmapped and write-only offsets read zero
  always_comb begin
    read_word = '0;
    unique case (acc_addr)
      OFF_COMPARE_A: begin
        read_word[CMP_W-1:0] = compare_a_q;
      end
      OFF_COMPARE_B: begin
        read_word[CMP_W-1:0] = compare_b_q;
      end
      OFF_STATUS: begin
        read_word[SRC_W-1:0]          = flags;
        read_word[BIT_TRANSMITTER_ON] = transmitter_on;
        read_word[BIT_RECEIVER_ON]    = receiver_on;
      end
      OFF_MASK_VIEW: begin
        read_word[SRC_W-1:0] = mask_q;
      end
      OFF_SYNC_CTRL: begin
        read_word[BIT_SYNC_EDGE_SELECT] = sync_edge_q;
      end
      default: begin
        read_word = '0;
      end
    endcase
  end

  // Read data captured at the address phase, held until the next read
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      hrdata_q <= RDATA_RESET;
    end else if (accept && !hwrite) begin
      hrdata_q <= read_word;
    end
  end

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_status_read;
    accept && !hwrite && (acc_addr == OFF_STATUS);
  endsequence

  sequence s_enable_write(int idx);
    accept && hwrite && (acc_addr == OFF_IRQ_ENABLE) ##1 hwdata[idx];
  endsequence

  sequence s_disable_write(int idx);
    accept && hwrite && (acc_addr == OFF_IRQ_DISABLE) ##1 hwdata[idx];
  endsequence

  a_bus_always_ready:
    assert property (hreadyout && (hresp == HRESP_OKAY))
    else $error("Slave must answer ready and OKAY");

  a_compare_a_store:
    assert property (accept && hwrite && (acc_addr == OFF_COMPARE_A)
                     ##1 1'b1 |=> compare_a_q == $past(hwdata[CMP_W-1:0]))
    else $error("Compare A did not take the written value");

  a_compare_b_store:
    assert property (accept && hwrite && (acc_addr == OFF_COMPARE_B)
                     ##1 1'b1 |=> compare_b_q == $past(hwdata[CMP_W-1:0]))
    else $error("Compare B did not take the written value");

  a_compare_upper_zero:
    assert property (accept && !hwrite && (acc_addr == OFF_COMPARE_A)
                     |=> hrdata[DATA_W-1:CMP_W] == '0)
    else $error("Compare A upper bits not zero");

  a_tx_free_read:
    assert property (s_status_read |=> hrdata[BIT_TX_HOLDING_FREE] == $past(tx_holding_free))
    else $error("Holding-free bit does not follow its source");

  a_tx_drained_read:
    assert property (s_status_read |=> hrdata[BIT_TX_FULLY_DRAINED] == $past(tx_fully_drained))
    else $error("Drained bit does not follow its source");

  a_tx_done_set:
    assert property (tx_count_reached_zero |=> sticky_q[BIT_TX_COUNT_DONE])
    else $error("Transmit count done not set");

  a_tx_done_clear:
    assert property (tx_count_written && !tx_count_reached_zero |=> !sticky_q[BIT_TX_COUNT_DONE])
    else $error("Transmit count done not cleared by counter write");

  a_tx_both_zero:
    assert property (s_status_read |=> hrdata[BIT_TX_COUNTS_BOTH_ZERO]
                     == $past(tx_count_is_zero && tx_next_count_is_zero))
    else $error("Transmit both-zero bit wrong");

  a_overrun_set:
    assert property (rx_word_load && rx_word_available |=> sticky_q[BIT_RX_OVERWRITE_FLAG])
    else $error("Overwrite flag not set");

  a_rx_done_clear:
    assert property (rx_count_written && !rx_count_reached_zero |=> !sticky_q[BIT_RX_COUNT_DONE])
    else $error("Receive count done not cleared by counter write");

  a_read_clears_flags:
    assert property (s_status_read ##0 !hit_a && !hit_b && !tx_sync_event && !rx_frame_sync_event
                     |=> sticky_q[BIT_RX_FRAME_SYNC_SEEN:BIT_COMPARE_A_HIT] == 4'h0)
    else $error("Status read did not clear event flags");

  a_compare_hit_holds:
    assert property (hit_b ##1 !status_read [*2] |=> sticky_q[BIT_COMPARE_B_HIT])
    else $error("Compare B flag lost before status read");

  a_sync_edge_pick:
    assert property (fs_sync_q && !fs_prev_q && (sync_edge_q == EDGE_RISING)
                     |=> sticky_q[BIT_TX_FRAME_SYNC_SEEN])
    else $error("Rising frame-sync edge not flagged");

  a_rx_sync_flag:
    assert property (rx_frame_sync_event |=> sticky_q[BIT_RX_FRAME_SYNC_SEEN])
    else $error("Receive sync flag not set");

  a_mask_enable:
    assert property (s_enable_write(BIT_COMPARE_A_HIT) |=> mask_q[BIT_COMPARE_A_HIT])
    else $error("Enable write did not set mask bit");

  a_mask_disable:
    assert property (s_disable_write(BIT_TX_HOLDING_FREE) |=> !mask_q[BIT_TX_HOLDING_FREE])
    else $error("Disable write did not clear mask bit");

  a_mask_view:
    assert property (accept && !hwrite && (acc_addr == OFF_MASK_VIEW)
                     |=> hrdata[SRC_W-1:0] == $past(mask_q))
    else $error("Mask view differs from mask");

  a_irq_from_flag:
    assert property (sticky_q[BIT_COMPARE_A_HIT] && mask_q[BIT_COMPARE_A_HIT] |-> irq)
    else $error("Interrupt low with enabled flag set");

  a_irq_quiet:
    assert property (mask_q == '0 |-> !irq)
    else $error("Interrupt high with all sources masked");

  a_mask_reset:
    assert property ($past(!rst_n) |-> mask_q == MASK_RESET)
    else $error("Mask not cleared after reset");

endmodule // serial_status_regs

`default_nettype wire

/* tb/sync_serial_status_irq_regs_test.sv */
/*
  Self-checking bench for the serial status, compare and interrupt-mask register bank.
  Assumes ssc_status_pkg and serial_status_regs are compiled first; one clock, no partner model.
*/
`timescale 1ns/10ps
`default_nettype none

module sync_serial_status_irq_regs_test;
  import ssc_status_pkg::*;

  // Status bits that a status read clears
  localparam logic [11:0] RD_CLR = 12'hF20;

  logic        clk;
  logic        rst_n;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic        hreadyout;
  logic        hresp;
  logic [31:0] hrdata;
  logic        irq;
  logic [31:0] lv;
  logic [7:0]  pv;
  logic [15:0] sw;
  logic        fs;
  logic        rd_dp;
  logic        irq_pb;
  logic [15:0] seed;
  logic [11:0] stk;
  logic [15:0] ca;
  logic [15:0] cb;
  logic [32:0] exp_q[$];
  int          error_cnt;
  int          comparisons;

  serial_status_regs uut (
    .clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .tx_holding_free(lv[0]), .tx_fully_drained(lv[1]), .tx_count_reached_zero(pv[0]),
    .tx_count_written(pv[1]), .tx_count_is_zero(lv[2]), .tx_next_count_is_zero(lv[3]),
    .tx_frame_sync_pin(fs), .transmitter_on(lv[16]), .rx_word_available(lv[4]), .rx_word_load(pv[2]),
    .rx_count_reached_zero(pv[3]), .rx_count_written(pv[4]), .rx_count_is_zero(lv[5]),
    .rx_next_count_is_zero(lv[6]), .rx_sync_word_valid(pv[5]), .rx_sync_word(sw),
    .rx_frame_sync_event(pv[6]), .receiver_on(lv[17]), .irq(irq));

  // Live status levels expected from the unit input word
  function automatic logic [31:0] lv_exp(input logic [31:0] w);
    logic [31:0] e;
    e = '0;
    e[BIT_TX_HOLDING_FREE] = w[0];
    e[BIT_TX_FULLY_DRAINED] = w[1];
    e[BIT_TX_COUNTS_BOTH_ZERO] = w[2] & w[3];
    e[BIT_RX_WORD_AVAILABLE] = w[4];
    e[BIT_RX_COUNTS_BOTH_ZERO] = w[5] & w[6];
    e[BIT_TRANSMITTER_ON] = w[16];
    e[BIT_RECEIVER_ON] = w[17];
    return e;
  endfunction

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  task automatic chk(input logic [31:0] got, input logic k);
    logic [32:0] e;
    comparisons++;
    if (exp_q.size() == 0) begin
      error_cnt++;
      $display("mismatch at %0t: expected nothing got %h", $time, got);
    end else begin
      e = exp_q.pop_front();
      if (e[32] !== k || e[31:0] !== got) begin
        error_cnt++;
        $display("mismatch at %0t: expected %h got %h", $time, e[31:0], got);
      end
    end
  endtask

  // Watches read data phases and interrupt probes
  always @(posedge clk) begin
    if (rd_dp === 1'b1 && hreadyout === 1'b1) chk(hrdata, 1'b0);
    if (irq_pb === 1'b1) chk({31'h0, irq}, 1'b1);
    if (rd_dp === 1'b1 && hresp !== HRESP_OKAY) begin
      error_cnt++;
      $display("mismatch at %0t: expected %h got %h", $time, HRESP_OKAY, hresp);
    end
  end

  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [31:0] e);
    @(posedge clk);
    htrans <= HTRANS_NONSEQ;
    haddr <= {24'h0, a};
    hwrite <= w;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    htrans <= HTRANS_IDLE;
    hwdata <= d;
    if (!w) exp_q.push_back({1'b0, e});
    rd_dp <= !w;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    rd_dp <= 1'b0;
  endtask

  task automatic rd_stat();
    bus(1'b0, OFF_STATUS, 32'h0, lv_exp(lv) | {20'h0, stk});
    stk = stk & ~RD_CLR;
  endtask

  task automatic irq_is(input logic e);
    @(posedge clk);
    exp_q.push_back({1'b1, 31'h0, e});
    irq_pb <= 1'b1;
    @(posedge clk);
    irq_pb <= 1'b0;
  endtask

  task automatic pulse(input logic [7:0] p);
    @(posedge clk);
    pv <= p;
    @(posedge clk);
    pv <= 8'h00;
  endtask

  task automatic setlv(input logic [31:0] v);
    @(posedge clk);
    lv <= v;
    // Let the new levels settle so a following read expects them
    @(posedge clk);
  endtask

  task automatic sync_pin(input logic v);
    fs <= v;
    repeat (6) @(posedge clk);
  endtask

  task automatic close_out();
    $display("comparisons %0d, mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    close_out();
  end

  initial begin
    logic [31:0] d;
    rst_n = 1'b0;
    hsel = 1'b1;
    haddr = 32'h0;
    htrans = HTRANS_IDLE;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    lv = 32'h0;
    pv = 8'h00;
    sw = 16'h0000;
    fs = 1'b0;
    rd_dp = 1'b0;
    irq_pb = 1'b0;
    seed = 16'h0062;
    stk = 12'h000;
    error_cnt = 0;
    comparisons = 0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    irq_is(1'b0);
    bus(1'b0, OFF_MASK_VIEW, 32'h0, 32'h0);
    bus(1'b0, OFF_COMPARE_B, 32'h0, 32'h0);
    bus(1'b0, OFF_IRQ_ENABLE, 32'h0, 32'h0);
    bus(1'b0, 8'h1C, 32'h0, 32'h0);
    for (int i = 0; i < 4; i++) begin
      seed = lfsr(seed);
      d = {~seed, seed};
      bus(1'b1, i[0] ? OFF_COMPARE_B : OFF_COMPARE_A, d, 32'h0);
      bus(1'b0, i[0] ? OFF_COMPARE_B : OFF_COMPARE_A, 32'h0, {16'h0, d[15:0]});
    end
    seed = lfsr(seed);
    ca = seed;
    cb = seed ^ 16'h5A5A;
    bus(1'b1, OFF_COMPARE_A, {16'hFFFF, ca}, 32'h0);
    bus(1'b1, OFF_COMPARE_B, {16'hFFFF, cb}, 32'h0);
    for (int i = 0; i < 10; i++) begin
      seed = lfsr(seed);
      setlv({14'h0, seed[8:7], 9'h0, seed[6:0]});
      rd_stat();
    end
    setlv(32'h0);
    pulse(8'h09);
    stk[BIT_TX_COUNT_DONE] = 1'b1;
    stk[BIT_RX_COUNT_DONE] = 1'b1;
    rd_stat();
    rd_stat();
    pulse(8'h02);
    stk[BIT_TX_COUNT_DONE] = 1'b0;
    rd_stat();
    pulse(8'h10);
    stk[BIT_RX_COUNT_DONE] = 1'b0;
    rd_stat();
    setlv(32'h10);
    pulse(8'h04);
    stk[BIT_RX_OVERWRITE_FLAG] = 1'b1;
    rd_stat();
    rd_stat();
    setlv(32'h0);
    pulse(8'h04);
    rd_stat();
    sw <= ca;
    pulse(8'h20);
    stk[BIT_COMPARE_A_HIT] = 1'b1;
    rd_stat();
    sw <= cb;
    pulse(8'h20);
    pulse(8'h40);
    stk[BIT_COMPARE_B_HIT] = 1'b1;
    stk[BIT_RX_FRAME_SYNC_SEEN] = 1'b1;
    rd_stat();
    sw <= ca ^ 16'h0001;
    pulse(8'h20);
    rd_stat();
    sync_pin(1'b1);
    stk[BIT_TX_FRAME_SYNC_SEEN] = 1'b1;
    rd_stat();
    rd_stat();
    sync_pin(1'b0);
    rd_stat();
    bus(1'b1, OFF_SYNC_CTRL, 32'h1, 32'h0);
    sync_pin(1'b1);
    rd_stat();
    sync_pin(1'b0);
    stk[BIT_TX_FRAME_SYNC_SEEN] = 1'b1;
    rd_stat();
    bus(1'b1, OFF_IRQ_ENABLE, 32'h0000_0FFF, 32'h0);
    irq_is(1'b0);
    bus(1'b0, OFF_MASK_VIEW, 32'h0, 32'h0000_0FFF);
    pulse(8'h40);
    irq_is(1'b1);
    bus(1'b1, OFF_IRQ_DISABLE, 32'h0000_0800, 32'h0);
    irq_is(1'b0);
    bus(1'b1, OFF_IRQ_DISABLE, 32'h0, 32'h0);
    bus(1'b1, OFF_IRQ_ENABLE, 32'h0, 32'h0);
    bus(1'b0, OFF_MASK_VIEW, 32'h0, 32'h0000_07FF);
    bus(1'b1, OFF_IRQ_ENABLE, 32'h0000_0800, 32'h0);
    irq_is(1'b1);
    stk[BIT_RX_FRAME_SYNC_SEEN] = 1'b1;
    rd_stat();
    irq_is(1'b0);
    setlv(32'h1);
    irq_is(1'b1);
    bus(1'b1, OFF_IRQ_DISABLE, 32'h0000_0FFF, 32'h0);
    irq_is(1'b0);
    bus(1'b0, OFF_MASK_VIEW, 32'h0, 32'h0);
    bus(1'b1, OFF_STATUS, 32'hFFFF_FFFF, 32'h0);
    rd_stat();
    close_out();
  end

endmodule // sync_serial_status_irq_regs_test

`default_nettype wire
